/* File: hw/isr_pkg.sv */
// Package for the instrument status reporting block: widths, bit positions,
// command codes and carrier structs. Assumes one instrument clock domain.
package isr_pkg;

  // Group and byte register widths.
  localparam int unsigned GRP_W  = 16;
  localparam int unsigned BYTE_W = 8;

  // Summary byte bit positions.
  localparam int unsigned SSB_UNUSED = 0;
  localparam int unsigned SSB_DEV    = 1;
  localparam int unsigned SSB_ERRQ   = 2;
  localparam int unsigned SSB_QUES   = 3;
  localparam int unsigned SSB_MAV    = 4;
  localparam int unsigned SSB_ESB    = 5;
  localparam int unsigned SSB_RQS    = 6;
  localparam int unsigned SSB_OPER   = 7;

  // Standard event bit positions.
  localparam int unsigned IEL_OPC    = 0;
  localparam int unsigned IEL_UNUSED = 1;
  localparam int unsigned IEL_PON    = 7;

  // Reset, preset and used-bit mask values.
  localparam logic [GRP_W-1:0]  PTR_PRESET = 16'hFFFF;
  localparam logic [GRP_W-1:0]  NTR_PRESET = 16'h0000;
  localparam logic [GRP_W-1:0]  GRP_MASK   = 16'h7FFF;
  localparam logic [BYTE_W-1:0] BYTE_ZERO  = 8'h00;
  localparam logic [GRP_W-1:0]  GRP_ZERO   = 16'h0000;

  // Group selectors.
  localparam logic [1:0] GSEL_OPER = 2'h0;
  localparam logic [1:0] GSEL_QUES = 2'h1;
  localparam logic [1:0] GSEL_DEV  = 2'h2;
  localparam int unsigned N_GRP    = 3;

  // Commands from the command parser, executed strictly in order.
  typedef enum logic [3:0] {
    ISR_CMD_CLS,
    ISR_CMD_PRESET,
    ISR_CMD_STB_Q,
    ISR_CMD_ESR_Q,
    ISR_CMD_ESE_W,
    ISR_CMD_ESE_Q,
    ISR_CMD_SRE_W,
    ISR_CMD_SRE_Q,
    ISR_CMD_COND_Q,
    ISR_CMD_EVT_Q,
    ISR_CMD_ENA_W,
    ISR_CMD_ENA_Q,
    ISR_CMD_PTR_W,
    ISR_CMD_PTR_Q,
    ISR_CMD_NTR_W,
    ISR_CMD_NTR_Q
  } isr_cmd_t;

  typedef struct packed {
    isr_cmd_t        cmd;
    logic [1:0]      grp;
    logic [GRP_W-1:0] data;
  } isr_req_t;

endpackage

/* File: hw/isr_group.sv */
// One generic status group: condition, transition filters, event latch, enable.
// Assumes condition bits are synchronous to i_mclk.
`timescale 1ns/100ps
module isr_group #(
  parameter int unsigned W = 16,
  parameter logic [W-1:0] USED = '1
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_sys_rst,
  // Live status
  input  wire logic [W-1:0] i_cond,
  // Controls
  input  wire logic         i_preset,
  input  wire logic         i_evt_clr,
  input  wire logic         i_ptr_wr,
  input  wire logic         i_ntr_wr,
  input  wire logic         i_ena_wr,
  input  wire logic [W-1:0] i_wdata,
  // State
  output logic [W-1:0]      o_cond,
  output logic [W-1:0]      o_ptr,
  output logic [W-1:0]      o_ntr,
  output logic [W-1:0]      o_event,
  output logic [W-1:0]      o_enable,
  output logic              o_summary
);
  logic [W-1:0] prev_q;
  logic [W-1:0] ptr_q;
  logic [W-1:0] ntr_q;
  logic [W-1:0] evt_q;
  logic [W-1:0] ena_q;
  logic [W-1:0] hit;

  assign o_cond = i_cond & USED;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      prev_q <= '0;
    end else begin
      prev_q <= o_cond;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || i_preset) begin
      ptr_q <= '1;
      ntr_q <= '0;
    end else begin
      if (i_ptr_wr) ptr_q <= i_wdata;
      if (i_ntr_wr) ntr_q <= i_wdata;
    end
  end

  assign hit = ((o_cond & ~prev_q & ptr_q) | (~o_cond & prev_q & ntr_q)) & USED;

  // Sticky event bits, set wins over clear.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      evt_q <= '0;
    end else if (i_evt_clr) begin
      evt_q <= hit;
    end else begin
      evt_q <= evt_q | hit;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ena_q <= '0;
    end else if (i_ena_wr) begin
      ena_q <= i_wdata & USED;
    end
  end

  assign o_ptr     = ptr_q & USED;
  assign o_ntr     = ntr_q & USED;
  assign o_event   = evt_q;
  assign o_enable  = ena_q;
  assign o_summary = |(evt_q & ena_q);

endmodule // isr_group

/* File: hw/isr_resp_reg.sv */
// Response holding register: the single answer word to the last query.
// Assumes the parser takes o_rsp_data while o_rsp_valid is high.
`timescale 1ns/100ps
module isr_resp_reg #(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_sys_rst,
  // Load and drain
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_take,
  // Answer
  output logic              o_valid,
  output logic [W-1:0]      o_data
);
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_data <= '0;
    end else if (i_load) begin
      o_data <= i_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_valid <= 1'b0;
    end else if (i_load) begin
      o_valid <= 1'b1;
    end else if (i_take) begin
      o_valid <= 1'b0;
    end
  end
endmodule // isr_resp_reg

/* File: hw/isr_top.sv */
// Status reporting top: three status groups, standard event latch, summary
// byte and service request logic behind an in-order command port.
// Assumes a command parser on i_mclk presents one command at a time.
//
// Behaviour
// - Every group has all component registers.
// - Condition mirrors live status, read-only.
// - Filter selects rising, falling or both.
// - Filters read-write, kept across clear.
// - Preset: negative zeros, positive ones.
// - Event bits stick until register cleared.
// - Event read-only; read or clear empties.
// - Summary is OR of event AND enable.
// - Enable read-write; reading keeps it.
// - Groups 16 bits; byte registers 8.
// - Bit 15 of groups reads zero.
// - Message available follows output data waiting.
// - Clearing events clears the summary bit.
// - Summary byte layout fixed, bit 0 zero.
// - Error summary clears on empty queue.
// - Service enable zero at power-up, write.
// - Byte query equals poll except bit 6 is the live request term; clears nothing.
// - Byte query runs in command order.
// - Standard event layout fixed, bit 1 zero.
// - Power-on bit set until read/clear.
// - Standard events clear on clear or query.
// - Standard enable zero at power-up, write.
`timescale 1ns/100ps
module isr_top
  import isr_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_sys_rst,
  // Command port
  input  wire logic                  i_req_valid,
  input  wire isr_pkg::isr_req_t     i_req,
  output logic                       o_req_ready,
  // Answer port
  output logic                       o_rsp_valid,
  output logic [isr_pkg::GRP_W-1:0]  o_rsp_data,
  input  wire logic                  i_rsp_take,
  // Live status from the instrument
  input  wire logic [isr_pkg::GRP_W-1:0]  i_oper_cond,
  input  wire logic [isr_pkg::GRP_W-1:0]  i_ques_cond,
  input  wire logic [isr_pkg::GRP_W-1:0]  i_dev_cond,
  input  wire logic                       i_errq_nonempty,
  input  wire logic                       i_outq_nonempty,
  // Standard event sources, one-cycle pulses
  input  wire logic [isr_pkg::BYTE_W-1:0] i_std_evt,
  // Serial poll by bus hardware
  input  wire logic                       i_spoll,
  // Status outputs
  output logic [isr_pkg::BYTE_W-1:0]      o_status_byte,
  output logic                            o_srq
);
  import isr_pkg::*;

  typedef enum {ST_IDLE, ST_ANSWER} isr_state_t;
  isr_state_t state_q;

  logic                  take;
  logic                  is_cmd;
  logic [N_GRP-1:0]      gsel;
  logic [N_GRP-1:0]      g_sum;
  logic [GRP_W-1:0]      g_cond [N_GRP];
  logic [GRP_W-1:0]      g_ptr  [N_GRP];
  logic [GRP_W-1:0]      g_ntr  [N_GRP];
  logic [GRP_W-1:0]      g_evt  [N_GRP];
  logic [GRP_W-1:0]      g_ena  [N_GRP];
  logic [GRP_W-1:0]      g_in   [N_GRP];
  logic [BYTE_W-1:0]     iel_q;
  logic [BYTE_W-1:0]     ese_q;
  logic [BYTE_W-1:0]     sre_q;
  logic                  pon_q;
  logic                  rqs_q;
  logic                  rqs_now;
  logic                  rqs_prev_q;
  logic [BYTE_W-1:0]     stb;
  logic                  rsp_load;
  logic [GRP_W-1:0]      rsp_d;
  logic [BYTE_W-1:0]     std_in;
  logic                  cls;
  logic                  esr_rd;

  function automatic logic hit(isr_cmd_t c);
    return take && (i_req.cmd == c);
  endfunction

  // One command taken at a time; a query is answered before the next.
  assign o_req_ready = (state_q == ST_IDLE);
  assign take        = i_req_valid && o_req_ready;
  assign is_cmd      = take;
  assign cls         = hit(ISR_CMD_CLS);
  assign esr_rd      = hit(ISR_CMD_ESR_Q);

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:   if (rsp_load) state_q <= ST_ANSWER;
        ST_ANSWER: if (i_rsp_take) state_q <= ST_IDLE;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  assign g_in[GSEL_OPER] = i_oper_cond;
  assign g_in[GSEL_QUES] = i_ques_cond;
  assign g_in[GSEL_DEV]  = i_dev_cond;

  // Full group per status source; 16 bits, top bit unused.
  for (genvar g = 0; g < N_GRP; g++) begin : g_grp
    assign gsel[g] = is_cmd && (i_req.grp == 2'(g));
    isr_group #(.W(GRP_W), .USED(GRP_MASK)) u_grp (
      .i_mclk    (i_mclk),
      .i_sys_rst (i_sys_rst),
      .i_cond    (g_in[g]),
      .i_preset  (hit(ISR_CMD_PRESET)),
      // Event query or clear empties the group.
      .i_evt_clr (cls || (gsel[g] && i_req.cmd == ISR_CMD_EVT_Q)),
      .i_ptr_wr  (gsel[g] && i_req.cmd == ISR_CMD_PTR_W),
      .i_ntr_wr  (gsel[g] && i_req.cmd == ISR_CMD_NTR_W),
      .i_ena_wr  (gsel[g] && i_req.cmd == ISR_CMD_ENA_W),
      .i_wdata   (i_req.data),
      .o_cond    (g_cond[g]),
      .o_ptr     (g_ptr[g]),
      .o_ntr     (g_ntr[g]),
      .o_event   (g_evt[g]),
      .o_enable  (g_ena[g]),
      .o_summary (g_sum[g])
    );
  end

  // Power-on flag caught after reset release.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      pon_q <= 1'b1;
    end else begin
      pon_q <= 1'b0;
    end
  end

  assign std_in = (i_std_evt | (pon_q ? BYTE_ZERO | (8'h01 << IEL_PON) : BYTE_ZERO))
                  & ~(8'h01 << IEL_UNUSED);

  // Sticky standard events; query or clear empties, set wins.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      iel_q <= BYTE_ZERO;
    end else if (cls || esr_rd) begin
      iel_q <= std_in;
    end else begin
      iel_q <= iel_q | std_in;
    end
  end

  // Standard enable zero at power-up and on write of zero.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ese_q <= BYTE_ZERO;
    end else if (hit(ISR_CMD_ESE_W)) begin
      ese_q <= i_req.data[BYTE_W-1:0];
    end
  end

  // Service enable zero at power-up and on write of zero.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      sre_q <= BYTE_ZERO;
    end else if (hit(ISR_CMD_SRE_W)) begin
      sre_q <= i_req.data[BYTE_W-1:0] & ~(8'h01 << SSB_RQS);
    end
  end

  // Summary byte built from live sources.
  always_comb begin
    stb             = BYTE_ZERO;
    stb[SSB_DEV]    = g_sum[GSEL_DEV];
    stb[SSB_ERRQ]   = i_errq_nonempty;
    stb[SSB_QUES]   = g_sum[GSEL_QUES];
    stb[SSB_MAV]    = i_outq_nonempty || (state_q == ST_ANSWER);
    stb[SSB_ESB]    = |(iel_q & ese_q);
    stb[SSB_OPER]   = g_sum[GSEL_OPER];
    rqs_now         = |(stb & sre_q);
    stb[SSB_RQS]    = rqs_q;
  end

  // Last cycle's request term, so that only a new request latches the bit.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rqs_prev_q <= 1'b0;
    end else begin
      rqs_prev_q <= rqs_now;
    end
  end

  // Request latch and poll clear.
  // A request that is still standing after a poll does not latch again.
  // A new request in the cycle of a poll wins, so that it is not lost.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rqs_q <= 1'b0;
    end else if (!rqs_now) begin
      rqs_q <= 1'b0;
    end else if (!rqs_prev_q) begin
      rqs_q <= 1'b1;
    end else if (i_spoll) begin
      rqs_q <= 1'b0;
    end
  end

  assign o_status_byte = stb;
  assign o_srq         = rqs_q;

  // Byte query returns the summary with the live request term in bit 6, clears nothing.
  always_comb begin
    rsp_load = 1'b0;
    rsp_d    = GRP_ZERO;
    if (take) begin
      rsp_load = 1'b1;
      case (i_req.cmd)
        ISR_CMD_STB_Q:  rsp_d = {8'h00, stb[BYTE_W-1:SSB_RQS+1], rqs_now,
                                 stb[SSB_RQS-1:0]};
        ISR_CMD_ESR_Q:  rsp_d = {8'h00, iel_q};
        ISR_CMD_ESE_Q:  rsp_d = {8'h00, ese_q};
        ISR_CMD_SRE_Q:  rsp_d = {8'h00, sre_q};
        ISR_CMD_COND_Q: rsp_d = g_cond[i_req.grp];
        ISR_CMD_EVT_Q:  rsp_d = g_evt[i_req.grp];
        ISR_CMD_ENA_Q:  rsp_d = g_ena[i_req.grp];
        ISR_CMD_PTR_Q:  rsp_d = g_ptr[i_req.grp];
        ISR_CMD_NTR_Q:  rsp_d = g_ntr[i_req.grp];
        default:        rsp_load = 1'b0;
      endcase
    end
  end

  isr_resp_reg #(.W(GRP_W)) u_rsp (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_load    (rsp_load),
    .i_data    (rsp_d),
    .i_take    (i_rsp_take),
    .o_valid   (o_rsp_valid),
    .o_data    (o_rsp_data)
  );

  sequence s_esr_read;
    esr_rd && !(|std_in);
  endsequence

  a_esr_clears: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    s_esr_read |=> (iel_q == BYTE_ZERO))
    else $error("standard event not cleared by query");

  a_bit1_zero: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    !iel_q[IEL_UNUSED])
    else $error("standard event bit 1 set");

  a_stb_bit0: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    !o_status_byte[SSB_UNUSED])
    else $error("summary byte bit 0 set");

  a_ques_top0: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    !g_evt[GSEL_QUES][GRP_W-1] && !g_cond[GSEL_OPER][GRP_W-1])
    else $error("group bit 15 set");

  a_stb_q_keep: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    take && i_req.cmd == ISR_CMD_STB_Q && !i_spoll |=> $stable(sre_q) && (rqs_q || !$past(rqs_q)))
    else $error("byte query disturbed summary");

  a_sre_zero: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    take && i_req.cmd == ISR_CMD_SRE_W && i_req.data == GRP_ZERO |=> sre_q == BYTE_ZERO)
    else $error("service enable not zeroed");

  a_ese_write: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    take && i_req.cmd == ISR_CMD_ESE_W |=> ese_q == $past(i_req.data[BYTE_W-1:0]))
    else $error("standard enable not written");

  a_esb_summary: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    o_status_byte[SSB_ESB] == |(iel_q & ese_q))
    else $error("standard summary mismatch");

  a_one_cmd: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    rsp_load |=> !o_req_ready)
    else $error("command taken while answer pending");

  a_pon_set: assert property (@(posedge i_mclk)
    $fell(i_sys_rst) |-> iel_q[IEL_PON] || pon_q)
    else $error("power-on bit missing");

  sequence s_clear_status;
    cls && !(|std_in);
  endsequence

  a_cls_empties: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    s_clear_status |=> (iel_q == BYTE_ZERO))
    else $error("standard event not cleared by clear status");

  a_poll_clears: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    i_spoll && rqs_prev_q |=> !o_srq)
    else $error("serial poll left request set");

  a_mav_pending: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    o_rsp_valid |-> o_status_byte[SSB_MAV])
    else $error("message available missing while answer waits");

endmodule // isr_top

/* File: tb/isr_ctrl_model.sv */
// Remote controller model: sends one command at a time and takes each answer.
// Assumes the status block answers on the same instrument clock.
`timescale 1ns/100ps
module isr_ctrl_model
  import isr_pkg::*;
(
  // Clock
  input  wire logic                      i_mclk,
  // Command port
  output logic                           o_req_valid,
  output isr_pkg::isr_req_t              o_req,
  input  wire logic                      i_req_ready,
  // Answer port
  input  wire logic                      i_rsp_valid,
  input  wire logic [isr_pkg::GRP_W-1:0] i_rsp_data,
  output logic                           o_rsp_take
);
  initial begin
    o_req_valid <= 1'b0;
    o_req       <= '0;
    o_rsp_take  <= 1'b0;
  end

  // The request is held until ready is seen at an edge; a query then waits for its answer.
  task automatic send(input isr_cmd_t c, input logic [1:0] g,
                      input logic [GRP_W-1:0] d, output logic [GRP_W-1:0] r);
    logic hit;
    begin
      r = '0;
      hit = 1'b0;
      @(posedge i_mclk);
      o_req_valid <= 1'b1;
      o_req       <= '{cmd: c, grp: g, data: d};
      while (!hit) begin
        @(negedge i_mclk);
        hit = (i_req_ready === 1'b1);
        @(posedge i_mclk);
      end
      o_req_valid <= 1'b0;
      o_req       <= isr_req_t'(~o_req);
      if (!(c inside {ISR_CMD_CLS, ISR_CMD_PRESET, ISR_CMD_ESE_W, ISR_CMD_SRE_W,
                      ISR_CMD_ENA_W, ISR_CMD_PTR_W, ISR_CMD_NTR_W})) begin
        hit = 1'b0;
        while (!hit) begin
          @(negedge i_mclk);
          hit = (i_rsp_valid === 1'b1);
          r   = i_rsp_data;
          @(posedge i_mclk);
        end
        o_rsp_take <= 1'b1;
        @(posedge i_mclk);
        o_rsp_take <= 1'b0;
      end
    end
  endtask
endmodule // isr_ctrl_model

/* File: tb/instrument_status_reporting_tb.sv */
// Self-checking bench for the status reporting top, driven by a controller model.
// Assumes one 125 MHz clock and a synchronous active-high reset.
`timescale 1ns/100ps
module instrument_status_reporting_tb;
  import isr_pkg::*;
  logic              i_mclk;
  logic              i_sys_rst;
  logic              req_valid;
  logic              req_ready;
  logic              rsp_valid;
  logic              rsp_take;
  logic              errq;
  logic              outq;
  logic              spoll;
  logic              srq;
  isr_req_t          req;
  logic [GRP_W-1:0]  rsp_data;
  logic [GRP_W-1:0]  r;
  logic [GRP_W-1:0]  cond [N_GRP];
  logic [BYTE_W-1:0] std_evt;
  logic [BYTE_W-1:0] stat;
  int                n_errors;
  int                n_compared;

  initial i_mclk = 1'b0;
  always #4 i_mclk = ~i_mclk;

  isr_top uut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_req_valid(req_valid),
    .i_req(req), .o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
    .i_rsp_take(rsp_take), .i_oper_cond(cond[0]), .i_ques_cond(cond[1]),
    .i_dev_cond(cond[2]), .i_errq_nonempty(errq), .i_outq_nonempty(outq),
    .i_std_evt(std_evt), .i_spoll(spoll), .o_status_byte(stat), .o_srq(srq));

  isr_ctrl_model ctl (.i_mclk(i_mclk), .o_req_valid(req_valid), .o_req(req),
    .i_req_ready(req_ready), .i_rsp_valid(rsp_valid), .i_rsp_data(rsp_data),
    .o_rsp_take(rsp_take));

  task automatic chk16(input logic [GRP_W-1:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s: got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic settle;
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask

  task automatic q(input isr_cmd_t c, input logic [1:0] g, input logic [GRP_W-1:0] d);
    ctl.send(c, g, d, r);
  endtask

  task automatic t_reset;
    q(ISR_CMD_ESR_Q, 2'h0, 16'h0000);
    chk16(r, 16'h0080, "power-on event"); // power-on bit
    q(ISR_CMD_ESR_Q, 2'h0, 16'h0000);
    chk16(r, 16'h0000, "query empties"); // read clears register
    q(ISR_CMD_SRE_Q, 2'h0, 16'h0000);
    chk16(r, 16'h0000, "sre at reset"); // zero at power-up
    q(ISR_CMD_ESE_Q, 2'h0, 16'h0000);
    chk16(r, 16'h0000, "ese at reset"); // zero at power-up
    $display("test reset done");
  endtask

  task automatic t_preset;
    q(ISR_CMD_PTR_W, 2'h2, 16'h0000);
    q(ISR_CMD_NTR_W, 2'h2, 16'hffff);
    q(ISR_CMD_PRESET, 2'h2, 16'h0000);
    q(ISR_CMD_NTR_Q, 2'h2, 16'h0000);
    chk16(r, 16'h0000, "ntr preset"); // negative filter zeros
    q(ISR_CMD_PTR_Q, 2'h2, 16'h0000);
    chk16(r & 16'h7fff, 16'h7fff, "ptr preset"); // positive filter ones
    @(posedge i_mclk);
    cond[0] <= 16'ha5a5;
    settle;
    q(ISR_CMD_COND_Q, 2'h0, 16'h0000);
    chk16(r, 16'h25a5, "live condition"); // mirror, top bit zero
    @(posedge i_mclk);
    cond[0] <= 16'h0000;
    $display("test preset done");
  endtask

  task automatic t_filter;
    q(ISR_CMD_PTR_W, 2'h1, 16'h0001);
    q(ISR_CMD_NTR_W, 2'h1, 16'h0002);
    q(ISR_CMD_EVT_Q, 2'h1, 16'h0000);
    @(posedge i_mclk);
    cond[1] <= 16'h0003;
    settle;
    @(posedge i_mclk);
    cond[1] <= 16'h0000;
    settle;
    @(posedge i_mclk);
    cond[1] <= 16'h0001;
    q(ISR_CMD_ENA_W, 2'h1, 16'h0004);
    settle;
    chk1(stat[SSB_QUES], 1'b0, "masked summary"); // disabled bits ignored
    q(ISR_CMD_ENA_W, 2'h1, 16'h0002);
    settle;
    chk1(stat[SSB_QUES], 1'b1, "enabled summary"); // event and enable
    q(ISR_CMD_EVT_Q, 2'h1, 16'h0000);
    chk16(r, 16'h0003, "filtered events"); // edge choice, bits stick
    settle;
    chk1(stat[SSB_QUES], 1'b0, "summary cleared"); // clear drops summary
    q(ISR_CMD_EVT_Q, 2'h1, 16'h0000);
    chk16(r, 16'h0000, "event cleared"); // read empties events
    q(ISR_CMD_ENA_Q, 2'h1, 16'h0000);
    q(ISR_CMD_ENA_Q, 2'h1, 16'h0000);
    chk16(r, 16'h0002, "enable kept"); // query keeps enable
    q(ISR_CMD_CLS, 2'h0, 16'h0000);
    q(ISR_CMD_PTR_Q, 2'h1, 16'h0000);
    chk16(r, 16'h0001, "ptr kept"); // filter survives clear
    q(ISR_CMD_NTR_Q, 2'h1, 16'h0000);
    chk16(r, 16'h0002, "ntr kept"); // filter survives clear
    $display("test filter done");
  endtask

  task automatic t_groups;
    int pos [N_GRP] = '{SSB_OPER, SSB_QUES, SSB_DEV};
    q(ISR_CMD_PRESET, 2'h0, 16'h0000);
    for (int g = 0; g < N_GRP; g++) begin
      q(ISR_CMD_ENA_W, 2'(g), 16'hffff);
      q(ISR_CMD_EVT_Q, 2'(g), 16'h0000);
      settle;
      chk16({8'h00, stat & 8'h8a}, 16'h0000, "no summaries"); // idle layout
      @(posedge i_mclk);
      cond[g] <= cond[g] ^ 16'hc010;
      settle;
      chk16({8'h00, stat & 8'h8a}, 16'(1 << pos[g]), "summary slot"); // bit place
      q(ISR_CMD_EVT_Q, 2'(g), 16'h0000);
      chk16(r, 16'h4010, "top bit dropped"); // width, bit 15 zero
      @(posedge i_mclk);
      cond[g] <= cond[g] ^ 16'hc010;
      q(ISR_CMD_ENA_W, 2'(g), 16'h0000);
    end
    $display("test groups done");
  endtask

  task automatic t_std;
    q(ISR_CMD_ESE_W, 2'h0, 16'h0004);
    q(ISR_CMD_SRE_W, 2'h0, 16'h0020);
    @(posedge i_mclk);
    std_evt <= 8'h06;
    @(posedge i_mclk);
    std_evt <= 8'h00;
    settle;
    chk1(stat[SSB_ESB], 1'b1, "std summary"); // enabled events reach byte
    chk1(srq, 1'b1, "request raised"); // enabled summary requests
    q(ISR_CMD_STB_Q, 2'h0, 16'h0000);
    chk16(r & 16'h00ef, 16'h0060, "byte query"); // same as poll value
    @(negedge i_mclk);
    chk1(srq, 1'b1, "query keeps request"); // query clears nothing
    @(posedge i_mclk);
    spoll <= 1'b1;
    @(posedge i_mclk);
    spoll <= 1'b0;
    settle;
    chk1(stat[SSB_RQS], 1'b0, "poll clears request"); // poll clears bit 6
    q(ISR_CMD_ESR_Q, 2'h0, 16'h0000);
    chk16(r, 16'h0004, "std layout"); // bit 1 reads zero
    settle;
    chk1(stat[SSB_ESB], 1'b0, "std summary cleared"); // query clears
    q(ISR_CMD_SRE_Q, 2'h0, 16'h0000);
    chk16(r, 16'h0020, "sre written"); // write then read
    q(ISR_CMD_SRE_W, 2'h0, 16'h0000);
    q(ISR_CMD_SRE_Q, 2'h0, 16'h0000);
    chk16(r, 16'h0000, "sre zeroed"); // write zero clears
    q(ISR_CMD_ESE_W, 2'h0, 16'h0000);
    q(ISR_CMD_ESE_Q, 2'h0, 16'h0000);
    chk16(r, 16'h0000, "ese zeroed"); // write zero clears
    $display("test standard done");
  endtask

  task automatic t_queues;
    @(posedge i_mclk);
    outq <= 1'b1;
    errq <= 1'b1;
    settle;
    chk16({8'h00, stat}, 16'h0014, "queues waiting"); // bits 4 and 2
    @(posedge i_mclk);
    outq <= 1'b0;
    errq <= 1'b0;
    settle;
    chk16({8'h00, stat}, 16'h0000, "queues empty"); // empty clears
    $display("test queues done");
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    n_errors   = 0;
    n_compared = 0;
    i_sys_rst  = 1'b1;
    cond[0]    = 16'h0000;
    cond[1]    = 16'h0000;
    cond[2]    = 16'h0000;
    errq       = 1'b0;
    outq       = 1'b0;
    std_evt    = 8'h00;
    spoll      = 1'b0;
    repeat (6) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    t_reset;
    t_preset;
    t_filter;
    t_groups;
    t_std;
    t_queues;
    test_done;
  end

  // The whole run needs about two hundred cycles.
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_errors++;
    $display("FAIL %0t watchdog expired", $time);
    test_done;
  end
endmodule // instrument_status_reporting_tb
